// File: design/aim_top.v
// Alarm flag holding, per-source masking and interrupt pin drive.
// Assumes alarm and clear inputs on clk; serial port pins are asynchronous.
`include "aim_defs.vh"

module aim_top #(
    parameter NSRC = 11
) (
    input  wire clk,
    input  wire rst,
    input  wire spi_sclk,
    input  wire spi_cs_n,
    input  wire spi_sdi,
    output wire spi_sdo,
    output wire spi_sdo_oe_n,
    input  wire reference_signal_loss,
    input  wire input1_signal_loss,
    input  wire input2_signal_loss,
    input  wire input3_signal_loss,
    input  wire input4_signal_loss,
    input  wire input1_freq_offset,
    input  wire input2_freq_offset,
    input  wire input3_freq_offset,
    input  wire input4_freq_offset,
    input  wire lock_loss,
    input  wire frame_alignment_alarm,
    input  wire reference_signal_loss_clear,
    input  wire input1_signal_loss_clear,
    input  wire input2_signal_loss_clear,
    input  wire input3_signal_loss_clear,
    input  wire input4_signal_loss_clear,
    input  wire input1_freq_offset_clear,
    input  wire input2_freq_offset_clear,
    input  wire input3_freq_offset_clear,
    input  wire input4_freq_offset_clear,
    input  wire lock_loss_clear,
    input  wire frame_alignment_alarm_clear,
    input  wire irq_pin_enable,
    input  wire irq_pin_polarity,
    output wire reference_signal_loss_flag,
    output wire input1_signal_loss_flag,
    output wire input2_signal_loss_flag,
    output wire input3_signal_loss_flag,
    output wire input4_signal_loss_flag,
    output wire input1_freq_offset_flag,
    output wire input2_freq_offset_flag,
    output wire input3_freq_offset_flag,
    output wire input4_freq_offset_flag,
    output wire lock_loss_flag,
    output wire frame_alignment_alarm_flag,
    output reg  irq_status_r,
    output reg  irq_pin_r,
    output reg  irq_pin_oe_n_r
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

function is_addr;
    input [`AIM_ADDR_W-1:0] a;
    input [`AIM_ADDR_W-1:0] target;
    begin
        is_addr = (a == target);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Serial register port

wire [2:0]             pins_s;
wire                   wr_pulse;
wire [`AIM_ADDR_W-1:0] reg_addr;
wire [`AIM_DATA_W-1:0] reg_wdata;
reg  [`AIM_DATA_W-1:0] reg_rdata;

aim_sync #(
    .WIDTH (3)
) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({spi_sclk, spi_cs_n, spi_sdi}),
    .sync_out (pins_s)
);

aim_spi_slave u_spi (
    .clk      (clk),
    .rst      (rst),
    .sclk_s   (pins_s[2]),
    .cs_n_s   (pins_s[1]),
    .sdi_s    (pins_s[0]),
    .rdata    (reg_rdata),
    .wr_pulse (wr_pulse),
    .addr     (reg_addr),
    .wdata    (reg_wdata),
    .sdo      (spi_sdo),
    .sdo_oe_n (spi_sdo_oe_n)
);

////////////////////////////////////////////////////////////////////////////////
// Mask registers

reg [`AIM_SIGLOSS_MASK_W-1:0] sigloss_mask_r;
reg [`AIM_OLA_MASK_W-1:0]     ola_mask_r;

always @(posedge clk) begin
    if (rst) begin
        sigloss_mask_r <= `AIM_SIGLOSS_MASK_RST;
        ola_mask_r     <= `AIM_OLA_MASK_RST;
    end else if (wr_pulse) begin
        // Upper bits of the write data are dropped
        if (is_addr(reg_addr, `AIM_SIGLOSS_MASK_ADDR))
            sigloss_mask_r <= reg_wdata[`AIM_SIGLOSS_MASK_W-1:0];
        if (is_addr(reg_addr, `AIM_OLA_MASK_ADDR))
            ola_mask_r <= reg_wdata[`AIM_OLA_MASK_W-1:0];
    end
end

always @* begin
    reg_rdata = `AIM_READ_NOMAP;
    if (is_addr(reg_addr, `AIM_SIGLOSS_MASK_ADDR))
        reg_rdata = {3'h0, sigloss_mask_r};
    else if (is_addr(reg_addr, `AIM_OLA_MASK_ADDR))
        reg_rdata = {2'h0, ola_mask_r};
end

////////////////////////////////////////////////////////////////////////////////
// Held alarm flags

wire [NSRC-1:0] alarm_in = {frame_alignment_alarm, lock_loss,
                            input4_freq_offset, input3_freq_offset,
                            input2_freq_offset, input1_freq_offset,
                            input4_signal_loss, input3_signal_loss,
                            input2_signal_loss, input1_signal_loss,
                            reference_signal_loss};
wire [NSRC-1:0] clear_in = {frame_alignment_alarm_clear, lock_loss_clear,
                            input4_freq_offset_clear, input3_freq_offset_clear,
                            input2_freq_offset_clear, input1_freq_offset_clear,
                            input4_signal_loss_clear, input3_signal_loss_clear,
                            input2_signal_loss_clear, input1_signal_loss_clear,
                            reference_signal_loss_clear};
reg  [NSRC-1:0] flags_r;
wire [NSRC-1:0] flags_nxt = (flags_r & ~clear_in) | alarm_in;

// Flags depend only on alarms and clears, so mask writes cannot touch them
always @(posedge clk) begin
    if (rst)
        flags_r <= {NSRC{1'b0}};
    else
        flags_r <= flags_nxt;
end

assign reference_signal_loss_flag = flags_r[0];
assign input1_signal_loss_flag    = flags_r[1];
assign input2_signal_loss_flag    = flags_r[2];
assign input3_signal_loss_flag    = flags_r[3];
assign input4_signal_loss_flag    = flags_r[4];
assign input1_freq_offset_flag    = flags_r[5];
assign input2_freq_offset_flag    = flags_r[6];
assign input3_freq_offset_flag    = flags_r[7];
assign input4_freq_offset_flag    = flags_r[8];
assign lock_loss_flag             = flags_r[9];
assign frame_alignment_alarm_flag = flags_r[10];

////////////////////////////////////////////////////////////////////////////////
// Mask mapping and interrupt

wire [NSRC-1:0] mask_all;

assign mask_all[0]  = sigloss_mask_r[`AIM_SL_REF_BIT];
assign mask_all[1]  = sigloss_mask_r[`AIM_SL_IN1_BIT];
assign mask_all[2]  = sigloss_mask_r[`AIM_SL_IN2_BIT];
assign mask_all[3]  = sigloss_mask_r[`AIM_SL_IN3_BIT];
assign mask_all[4]  = sigloss_mask_r[`AIM_SL_IN4_BIT];
assign mask_all[5]  = ola_mask_r[`AIM_OLA_IN1_BIT];
assign mask_all[6]  = ola_mask_r[`AIM_OLA_IN2_BIT];
assign mask_all[7]  = ola_mask_r[`AIM_OLA_IN3_BIT];
assign mask_all[8]  = ola_mask_r[`AIM_OLA_IN4_BIT];
assign mask_all[9]  = ola_mask_r[`AIM_OLA_LOCK_BIT];
assign mask_all[10] = ola_mask_r[`AIM_OLA_ALIGN_BIT];

wire irq_status_nxt = |(flags_r & ~mask_all);

always @(posedge clk) begin
    if (rst) begin
        irq_status_r   <= 1'b0;
        irq_pin_r      <= 1'b1;
        irq_pin_oe_n_r <= 1'b1;
    end else begin
        irq_status_r   <= irq_status_nxt;
        irq_pin_oe_n_r <= ~irq_pin_enable;
        // Released pin still holds the inactive level
        if (irq_pin_enable)
            irq_pin_r <= irq_pin_polarity ? irq_status_nxt : ~irq_status_nxt;
        else
            irq_pin_r <= ~irq_pin_polarity;
    end
end

endmodule

// File: design/aim_defs.vh
// Constants for the alarm interrupt mask block: offsets, fields, reset values.
// Assumes inclusion by bare name from the design files.
`ifndef AIM_DEFS_VH
`define AIM_DEFS_VH

`define AIM_ADDR_W            7
`define AIM_DATA_W            8
`define AIM_SIGLOSS_MASK_ADDR 7'h17
`define AIM_OLA_MASK_ADDR     7'h18
`define AIM_SIGLOSS_MASK_W    5
`define AIM_OLA_MASK_W        6
`define AIM_SIGLOSS_MASK_RST  5'h1f
`define AIM_OLA_MASK_RST      6'h3f
`define AIM_READ_NOMAP        8'h00

// Field positions, signal-loss mask register
`define AIM_SL_REF_BIT        0
`define AIM_SL_IN1_BIT        1
`define AIM_SL_IN2_BIT        2
`define AIM_SL_IN3_BIT        3
`define AIM_SL_IN4_BIT        4

// Field positions, offset/lock/alignment mask register
`define AIM_OLA_LOCK_BIT      0
`define AIM_OLA_IN1_BIT       1
`define AIM_OLA_IN2_BIT       2
`define AIM_OLA_IN3_BIT       3
`define AIM_OLA_IN4_BIT       4
`define AIM_OLA_ALIGN_BIT     5

// Serial frame: read bit, 7 address bits, 8 data bits
`define AIM_FRAME_BITS        5'h10
`define AIM_HEAD_LAST         5'h07
`define AIM_DATA_FIRST        5'h08
`define AIM_FRAME_LAST        5'h0f

`endif

// File: design/aim_sync.v
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is asynchronous to clk and only its level matters.
module aim_sync #(
    parameter WIDTH = 3
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_r;

always @(posedge clk) begin
    if (rst) begin
        meta_r   <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end else begin
        meta_r   <= async_in;
        sync_out <= meta_r;
    end
end

endmodule

// File: design/aim_spi_slave.v
// Serial register port slave, mode 0, MSB first, 16-bit frames.
// Assumes synchronised pins and a master clock well below clk/4.
`include "aim_defs.vh"

module aim_spi_slave (
    input  wire                   clk,
    input  wire                   rst,
    input  wire                   sclk_s,
    input  wire                   cs_n_s,
    input  wire                   sdi_s,
    input  wire [`AIM_DATA_W-1:0] rdata,
    output reg                    wr_pulse,
    output reg  [`AIM_ADDR_W-1:0] addr,
    output reg  [`AIM_DATA_W-1:0] wdata,
    output reg                    sdo,
    output reg                    sdo_oe_n
);

reg                   sclk_d_r;
reg [4:0]             cnt_r;
reg [6:0]             shin_r;
reg [`AIM_DATA_W-1:0] shout_r;
reg                   rd_r;

wire rise = sclk_s & ~sclk_d_r;
wire fall = ~sclk_s & sclk_d_r;

always @(posedge clk) begin
    if (rst) begin
        sclk_d_r <= 1'b0;
        cnt_r    <= 5'h00;
        shin_r   <= 7'h00;
        shout_r  <= 8'h00;
        rd_r     <= 1'b0;
        wr_pulse <= 1'b0;
        addr     <= 7'h00;
        wdata    <= 8'h00;
        sdo      <= 1'b0;
        sdo_oe_n <= 1'b1;
    end else begin
        sclk_d_r <= sclk_s;
        wr_pulse <= 1'b0;
        if (cs_n_s) begin
            cnt_r    <= 5'h00;
            sdo_oe_n <= 1'b1;
        end else begin
            if (rise && cnt_r != `AIM_FRAME_BITS) begin
                shin_r <= {shin_r[5:0], sdi_s};
                cnt_r  <= cnt_r + 5'h01;
                if (cnt_r == `AIM_HEAD_LAST) begin
                    rd_r <= shin_r[6];
                    addr <= {shin_r[5:0], sdi_s};
                end
                if (cnt_r == `AIM_FRAME_LAST && !rd_r) begin
                    wr_pulse <= 1'b1;
                    wdata    <= {shin_r[6:0], sdi_s};
                end
            end
            // Read data leaves on falling edges so the master samples on rising
            if (fall && rd_r && cnt_r >= `AIM_DATA_FIRST && cnt_r <= `AIM_FRAME_LAST) begin
                sdo_oe_n <= 1'b0;
                if (cnt_r == `AIM_DATA_FIRST) begin
                    sdo     <= rdata[7];
                    shout_r <= {rdata[6:0], 1'b0};
                end else begin
                    sdo     <= shout_r[7];
                    shout_r <= {shout_r[6:0], 1'b0};
                end
            end
        end
    end
end

endmodule

// File: sim/aim_top_asserts.sv
// Checker for aim_top: flag holding and interrupt pin drive.
// Assumes binding to aim_top; one clock, synchronous reset.
module aim_asserts (
    input wire logic clk, rst, irq_pin_enable, irq_pin_polarity,
    input wire logic irq_status_r, irq_pin_r, irq_pin_oe_n_r,
    input wire logic input1_signal_loss, input1_signal_loss_clear, input1_signal_loss_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    wire a = input1_signal_loss;
    wire c = input1_signal_loss_clear;
    wire f = input1_signal_loss_flag;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_set; a |=> f; endproperty
    property p_hold; f && !c |=> f; endproperty
    property p_clear; c && !a |=> !f; endproperty
    property p_no_self; !f && !a |=> !f; endproperty
    property p_oe_on; irq_pin_enable |=> !irq_pin_oe_n_r; endproperty
    property p_oe_off; !irq_pin_enable |=> irq_pin_oe_n_r; endproperty
    property p_lvl_on; irq_pin_enable |=> irq_pin_r == ($past(irq_pin_polarity) ~^ irq_status_r); endproperty
    property p_lvl_off; !irq_pin_enable |=> irq_pin_r == !$past(irq_pin_polarity); endproperty
    a_set: assert property (p_set)
        else $error("flag not set");
    a_hold: assert property (p_hold)
        else $error("flag lost");
    a_clear: assert property (p_clear)
        else $error("flag not cleared");
    a_no_self: assert property (p_no_self)
        else $error("flag set by itself");
    a_oe_on: assert property (p_oe_on)
        else $error("pin not driven");
    a_oe_off: assert property (p_oe_off)
        else $error("pin driven while disabled");
    a_lvl_on: assert property (p_lvl_on)
        else $error("pin level wrong");
    a_lvl_off: assert property (p_lvl_off)
        else $error("disabled pin not inactive");
    c_irq: cover property ($rose(irq_status_r));
    c_pin_off: cover property ($rose(irq_pin_oe_n_r));
    c_clear: cover property (f && c);
endmodule

bind aim_top aim_asserts u_chk (
    .clk(clk), .rst(rst), .irq_pin_enable(irq_pin_enable), .irq_pin_polarity(irq_pin_polarity),
    .irq_status_r(irq_status_r), .irq_pin_r(irq_pin_r), .irq_pin_oe_n_r(irq_pin_oe_n_r),
    .input1_signal_loss(input1_signal_loss), .input1_signal_loss_clear(input1_signal_loss_clear),
    .input1_signal_loss_flag(input1_signal_loss_flag)
);

// File: sim/aim_host.sv
// Host model on the serial register port: 16-bit frames, mode 0.
// Assumes each serial clock phase lasts five system clocks.
module aim_host (
    input  wire logic clk,
    input  wire logic sdo,
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd, output logic [7:0] q);
        logic [15:0] fr;
        fr = {rd, a, wd};
        q = 8'h00;
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi = fr[i];
            tick(5);
            q = {q[6:0], sdo};
            sclk = 1'b1;
            tick(5);
            sclk = 1'b0;
        end
        tick(5);
        cs_n = 1'b1;
        // Deselected line: no stale value
        sdi = ~sdi;
        tick(6);
    endtask
endmodule

// File: sim/aim_top_tb_top.sv
// Testbench for aim_top: mask registers, held flags, interrupt pin.
// Assumes aim_host drives the serial port; alarms driven from here.
module aim_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        en  = 1'b1;
    logic        pol = 1'b1;
    logic [10:0] alm = 11'h000;
    logic [10:0] clr = 11'h000;
    logic [7:0]  v, sl, ola;
    wire  [10:0] flg;
    wire         st, pin, oen, sclk, csn, sdi, sdo, sdo_oen;
    int          n_fail = 0;
    int          tests_run = 0;
    int          cyc = 0;
    always #2.5 clk = ~clk;
    aim_top uut (
        .clk(clk), .rst(rst), .spi_sclk(sclk), .spi_cs_n(csn), .spi_sdi(sdi), .spi_sdo(sdo),
        .spi_sdo_oe_n(sdo_oen), .reference_signal_loss(alm[0]), .input1_signal_loss(alm[1]),
        .input2_signal_loss(alm[2]), .input3_signal_loss(alm[3]), .input4_signal_loss(alm[4]),
        .input1_freq_offset(alm[5]), .input2_freq_offset(alm[6]), .input3_freq_offset(alm[7]),
        .input4_freq_offset(alm[8]), .lock_loss(alm[9]), .frame_alignment_alarm(alm[10]),
        .reference_signal_loss_clear(clr[0]), .input1_signal_loss_clear(clr[1]),
        .input2_signal_loss_clear(clr[2]), .input3_signal_loss_clear(clr[3]),
        .input4_signal_loss_clear(clr[4]), .input1_freq_offset_clear(clr[5]),
        .input2_freq_offset_clear(clr[6]), .input3_freq_offset_clear(clr[7]),
        .input4_freq_offset_clear(clr[8]), .lock_loss_clear(clr[9]), .frame_alignment_alarm_clear(clr[10]),
        .irq_pin_enable(en), .irq_pin_polarity(pol), .reference_signal_loss_flag(flg[0]),
        .input1_signal_loss_flag(flg[1]), .input2_signal_loss_flag(flg[2]), .input3_signal_loss_flag(flg[3]),
        .input4_signal_loss_flag(flg[4]), .input1_freq_offset_flag(flg[5]), .input2_freq_offset_flag(flg[6]),
        .input3_freq_offset_flag(flg[7]), .input4_freq_offset_flag(flg[8]), .lock_loss_flag(flg[9]),
        .frame_alignment_alarm_flag(flg[10]), .irq_status_r(st), .irq_pin_r(pin), .irq_pin_oe_n_r(oen)
    );
    aim_host host (.clk(clk), .sdo(sdo ^ sdo_oen), .sclk(sclk), .cs_n(csn), .sdi(sdi));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d, v);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        host.xfer(1'b1, a, 8'h00, v);
        chk(v, e);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        step(16);
        rst = 1'b0;
        step(4);
        rd(7'h17, 8'h1f);
        rd(7'h18, 8'h3f);
        rd(7'h20, 8'h00);
        wr(7'h20, 8'h00);
        rd(7'h17, 8'h1f);
        wr(7'h18, 8'hff);
        rd(7'h18, 8'h3f);
        wr(7'h17, 8'he0);
        rd(7'h17, 8'h00);
        wr(7'h17, 8'h1f);
        $display("test registers done");
        for (int i = 0; i < 11; i++) begin
            sl = (i < 5) ? 8'h1f & ~(8'h01 << i) : 8'h1f;
            ola = (i < 5) ? 8'h3f : 8'h3f & ~(8'h01 << (i == 10 ? 5 : (i - 4) % 5));
            alm[i] = 1'b1;
            step(1);
            alm[i] = 1'b0;
            step(2);
            chk({6'h00, st, flg[i]}, 8'h01);
            wr(7'h17, sl);
            wr(7'h18, ola);
            chk({5'h00, st, pin, flg[i]}, 8'h07);
            wr(7'h17, 8'h1f);
            wr(7'h18, 8'h3f);
            chk({5'h00, st, pin, flg[i]}, 8'h01);
            clr[i] = 1'b1;
            step(1);
            clr[i] = 1'b0;
            step(2);
            chk({7'h00, flg[i]}, 8'h00);
        end
        $display("test masking done");
        wr(7'h17, 8'h1e);
        alm[0] = 1'b1;
        step(1);
        alm[0] = 1'b0;
        pol = 1'b0;
        step(2);
        chk({6'h00, pin, oen}, 8'h00);
        en = 1'b0;
        step(2);
        chk({6'h00, pin, oen}, 8'h03);
        $display("test pin drive done");
        report_and_stop();
    end
endmodule
